//--- src/status_ctrl_pkg.sv
// constants, field positions and codes for the status pin and ref select bank
// Overview of operation
// - lock pin source picks one of nineteen status signals by 5-bit code.
// - output type 3 passes the signal, type 4 inverts it.
// - lock pin type codes: 3 push-pull, 4 inverted, 5 open-source, 6 open-drain.
// - gating bits hold realignment asserted until the chosen loop locks.
// - tracking makes the DAC follow first-loop tuning outside holdover; count always readable.
// - holdover field: 1 disables, 2 enables, 0 and 3 reserved.
// - holdover pin source uses the same nineteen-entry code as lock pin.
// - holdover pin type codes 3 to 6 as for the lock pin.
// - input-1 status pin source by 3-bit code, ignored while pin is input.
// - input-0 status pin type: 0-2 inputs, 3-6 output kinds.
// - input-0 status pin source by 3-bit code, ignored while pin is input.
// - first-loop lock falling enters holdover and switches, unless ignore bit set.
// - reference mode: 0-2 forced, 3 pins, 4 auto, 6 auto with pin next.
// - select pins active high with polarity 0, active low with 1.
// - auto switching skips disabled inputs, order 0, 1, 2, back to 0.
// - input loss asserts after inactivity of 1200, 206, 52.9 or 23.7 ns.
package status_ctrl_pkg;
  localparam logic [4:0] ADDR_LOCK_HOLD = 5'h0c;
  localparam logic [4:0] ADDR_PINS_REF = 5'h0d;
  localparam logic [4:0] ADDR_LOSS_CFG = 5'h0e;
  localparam logic [31:0] RST_LOCK_HOLD = 32'h0300_004c;
  localparam logic [31:0] RST_PINS_REF = 32'h0300_00ed;
  localparam logic [31:0] RST_LOSS_CFG = 32'h0000_000e;
  localparam int WORD_W = 32;
  localparam int ADDR_HI = 4;
  localparam int SRC_HI = 31;
  localparam int SRC_LO = 27;
  localparam int TYPE_HI = 26;
  localparam int TYPE_LO = 24;
  localparam int REALIGN2_BIT = 23;
  localparam int REALIGN1_BIT = 22;
  localparam int TRACK_BIT = 8;
  localparam int HMODE_HI = 7;
  localparam int HMODE_LO = 6;
  localparam int IN1_SEL_HI = 22;
  localparam int IN1_SEL_LO = 20;
  localparam int IN0_TYPE_HI = 18;
  localparam int IN0_TYPE_LO = 16;
  localparam int IGNORE_BIT = 15;
  localparam int IN0_SEL_HI = 14;
  localparam int IN0_SEL_LO = 12;
  localparam int MODE_HI = 11;
  localparam int MODE_LO = 9;
  localparam int POL_BIT = 8;
  localparam int EN_HI = 7;
  localparam int EN_LO = 5;
  localparam int LOS_HI = 31;
  localparam int LOS_LO = 30;
  localparam int DAC_W = 10;
  localparam int RB_DAC_LO = 14;
  localparam int SRC_COUNT = 19;
  localparam int SMALL_COUNT = 7;
  localparam real CLK_PERIOD_NS = 8.0;
  localparam real LOS_T0_NS = 1200.0;
  localparam real LOS_T1_NS = 206.0;
  localparam real LOS_T2_NS = 52.9;
  localparam real LOS_T3_NS = 23.7;
  localparam int LOS_CYC0 = int'($ceil(LOS_T0_NS / CLK_PERIOD_NS));
  localparam int LOS_CYC1 = int'($ceil(LOS_T1_NS / CLK_PERIOD_NS));
  localparam int LOS_CYC2 = int'($ceil(LOS_T2_NS / CLK_PERIOD_NS));
  localparam int LOS_CYC3 = int'($ceil(LOS_T3_NS / CLK_PERIOD_NS));
  localparam logic [1:0] HOLD_DIS = 2'h1;
  localparam logic [1:0] HOLD_EN = 2'h2;
  typedef enum logic [2:0] {
    PT_IN = 3'h0, PT_IN_PU = 3'h1, PT_IN_PD = 3'h2, PT_PP = 3'h3,
    PT_INV = 3'h4, PT_OS = 3'h5, PT_OD = 3'h6, PT_RSV = 3'h7
  } pin_type_t;
  typedef enum logic [2:0] {
    RM_FORCE0 = 3'h0, RM_FORCE1 = 3'h1, RM_FORCE2 = 3'h2, RM_PINS = 3'h3,
    RM_AUTO = 3'h4, RM_RSV5 = 3'h5, RM_AUTO_PIN = 3'h6, RM_RSV7 = 3'h7
  } ref_mode_t;
  typedef enum logic [0:0] {HS_NORMAL = 1'b0, HS_HOLD = 1'b1} hold_state_t;
endpackage

//--- src/status_pin_driver.sv
// output stage of one status pin: polarity and drive kind by type code
`timescale 1ns/1ps
module status_pin_driver (
  input wire logic clock, // core clock
  input wire logic rst_n, // sync reset
  input wire logic sig, // selected status signal
  input wire logic [2:0] ptype, // pin type code
  output logic pin_drive, // level driven
  output logic pin_oe // high while driving
);
  import status_ctrl_pkg::*;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_drive <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      unique case (pin_type_t'(ptype))
        PT_PP: begin pin_drive <= sig; pin_oe <= 1'b1; end
        PT_INV: begin pin_drive <= !sig; pin_oe <= 1'b1; end
        PT_OS: begin pin_drive <= 1'b1; pin_oe <= sig; end
        PT_OD: begin pin_drive <= 1'b0; pin_oe <= !sig; end
        // inputs and reserved codes release the pin
        default: begin pin_drive <= 1'b0; pin_oe <= 1'b0; end
      endcase
    end
  end
endmodule

//--- src/ref_loss_monitor.sv
// inactivity watchdog on one reference input pin
`timescale 1ns/1ps
module ref_loss_monitor (
  input wire logic clock, // core clock
  input wire logic rst_n, // sync reset
  input wire logic ref_pin, // raw reference input
  input wire logic [1:0] timeout_sel, // timeout code
  output logic absent // input absent flag
);
  import status_ctrl_pkg::*;
  logic s1_r, s2_r, s3_r;
  logic [7:0] idle_r;
  logic [7:0] limit;
  always_comb begin
    unique case (timeout_sel)
      2'h0: limit = 8'(LOS_CYC0);
      2'h1: limit = 8'(LOS_CYC1);
      2'h2: limit = 8'(LOS_CYC2);
      default: limit = 8'(LOS_CYC3);
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= ref_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // any edge counts as activity; a fast input only aliases, never stalls
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idle_r <= 8'h00;
      absent <= 1'b1;
    end else if (s2_r != s3_r) begin
      idle_r <= 8'h00;
      absent <= 1'b0;
    end else begin
      if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
      // nine bits so the saturated count cannot wrap back to zero
      absent <= ({1'b0, idle_r} + 9'h001 >= {1'b0, limit});
    end
  end
endmodule

//--- src/status_ctrl.sv
// status pin muxing, holdover, realignment gating and reference choice
`timescale 1ns/1ps
module status_ctrl (
  input wire logic clock, // core clock, 125 MHz
  input wire logic rst_n, // sync reset, active low
  input wire logic cfg_clk, // serial port clock pin
  input wire logic cfg_data, // serial port data pin
  input wire logic cfg_latch, // serial port latch pin
  input wire logic first_lock, // first loop digital lock flag
  input wire logic second_lock, // second loop digital lock flag
  input wire logic dac_locked, // DAC locked flag
  input wire logic dac_rail, // DAC at rail
  input wire logic dac_low, // DAC below low trip
  input wire logic dac_high, // DAC above high trip
  input wire logic [7:0] div_taps, // loop divider outputs and halves
  input wire logic [9:0] tune_level, // first loop tuning level
  input wire logic [2:0] ref_in, // reference input pins
  input wire logic in0_pin_level, // input-0 status pin level
  input wire logic in1_pin_level, // input-1 status pin level
  output logic lock_pin, // lock status pin drive
  output logic lock_pin_oe, // lock status pin enable
  output logic hold_pin, // holdover status pin drive
  output logic hold_pin_oe, // holdover status pin enable
  output logic in0_pin_drive, // input-0 status pin drive
  output logic in0_pin_oe, // input-0 status pin enable
  output logic in1_pin_drive, // input-1 status pin drive
  output logic in1_pin_oe, // input-1 status pin enable
  output logic [1:0] ref_choice, // chosen first loop reference
  output logic holdover_active, // holdover state
  output logic switch_event, // clock switch event pulse
  output logic realign_hold, // output realignment held
  output logic [9:0] dac_count_readback // tracked DAC count
);
  import status_ctrl_pkg::*;

  localparam int NSYNC = 19;
  logic [NSYNC-1:0] s1_r, s2_r;
  logic clk_d_r, latch_d_r, lock1_d_r;
  logic [WORD_W-1:0] shift_r, rb_shift_r;
  logic [WORD_W-1:0] lock_hold_r, pins_ref_r, loss_cfg_r;
  logic [1:0] choice_r;
  hold_state_t hold_r;
  logic event_r, realign_r;
  logic [DAC_W-1:0] dac_r;
  logic [2:0] absent;

  // two-stage synchroniser for every pin-side input except tune_level, taken direct, and ref_in, which the loss monitors synchronise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {cfg_clk, cfg_data, cfg_latch, first_lock, second_lock,
               dac_locked, dac_rail, dac_low, dac_high, div_taps,
               in0_pin_level, in1_pin_level};
      s2_r <= s1_r;
    end
  end

  logic sc_clk, sc_data, sc_latch, lk1, lk2, dlk, drail, dlo, dhi;
  logic [7:0] taps;
  logic p0, p1;
  assign {sc_clk, sc_data, sc_latch, lk1, lk2, dlk, drail, dlo, dhi, taps,
          p0, p1} = s2_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_d_r <= 1'b0;
      latch_d_r <= 1'b0;
      lock1_d_r <= 1'b0;
    end else begin
      clk_d_r <= sc_clk;
      latch_d_r <= sc_latch;
      lock1_d_r <= lk1;
    end
  end

  logic clk_rise, latch_rise, lock1_fall;
  assign clk_rise = sc_clk && !clk_d_r;
  assign latch_rise = sc_latch && !latch_d_r;
  assign lock1_fall = lock1_d_r && !lk1;

  // serial word shifts in msb first; the low bits carry the address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (clk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], sc_data};
    end
  end

  // fields move only on latch, so pins never see a half-shifted word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_hold_r <= RST_LOCK_HOLD;
      pins_ref_r <= RST_PINS_REF;
      loss_cfg_r <= RST_LOSS_CFG;
    end else if (latch_rise) begin
      if (shift_r[ADDR_HI:0] == ADDR_LOCK_HOLD) lock_hold_r <= shift_r;
      if (shift_r[ADDR_HI:0] == ADDR_PINS_REF) pins_ref_r <= shift_r;
      if (shift_r[ADDR_HI:0] == ADDR_LOSS_CFG) loss_cfg_r <= shift_r;
    end
  end

  // readback word loads on latch, shifts out one bit per serial clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rb_shift_r <= '0;
    end else if (latch_rise) begin
      rb_shift_r <= WORD_W'({dac_r, RB_DAC_LO'(0)});
    end else if (clk_rise) begin
      rb_shift_r <= {rb_shift_r[WORD_W-2:0], 1'b0};
    end
  end

  logic rb_bit;
  assign rb_bit = rb_shift_r[WORD_W-1];

  logic [4:0] lock_sel, hold_sel;
  logic [2:0] lock_type, hold_type, in0_type, in1_type, in0_sel, in1_sel;
  logic [1:0] hmode, los_sel;
  logic [2:0] en;
  logic ignore, pol, track;
  ref_mode_t mode;
  assign lock_sel = lock_hold_r[SRC_HI:SRC_LO];
  assign lock_type = lock_hold_r[TYPE_HI:TYPE_LO];
  assign hmode = lock_hold_r[HMODE_HI:HMODE_LO];
  assign track = lock_hold_r[TRACK_BIT];
  assign hold_sel = pins_ref_r[SRC_HI:SRC_LO];
  assign hold_type = pins_ref_r[TYPE_HI:TYPE_LO];
  assign in1_sel = pins_ref_r[IN1_SEL_HI:IN1_SEL_LO];
  assign in0_type = pins_ref_r[IN0_TYPE_HI:IN0_TYPE_LO];
  assign ignore = pins_ref_r[IGNORE_BIT];
  assign in0_sel = pins_ref_r[IN0_SEL_HI:IN0_SEL_LO];
  assign mode = ref_mode_t'(pins_ref_r[MODE_HI:MODE_LO]);
  assign pol = pins_ref_r[POL_BIT];
  assign en = pins_ref_r[EN_HI:EN_LO];
  assign los_sel = loss_cfg_r[LOS_HI:LOS_LO];
  assign in1_type = loss_cfg_r[TYPE_HI:TYPE_LO];

  function automatic logic pick_src(input logic [4:0] sel,
                                    input logic [SRC_COUNT-1:0] v);
    pick_src = (sel < 5'(SRC_COUNT)) ? v[sel] : 1'b0;
  endfunction

  function automatic logic pick_small(input logic [2:0] sel,
                                      input logic [SMALL_COUNT-1:0] v);
    pick_small = (sel < 3'(SMALL_COUNT)) ? v[sel] : 1'b0;
  endfunction

  function automatic logic [1:0] next_ref(input logic [1:0] cur,
                                          input logic [2:0] ena);
    logic [1:0] a, b;
    a = (cur == 2'h2) ? 2'h0 : cur + 2'h1;
    b = (a == 2'h2) ? 2'h0 : a + 2'h1;
    if (ena[a]) next_ref = a;
    else if (ena[b]) next_ref = b;
    else next_ref = cur;
  endfunction

  // codes 11..18 are the divider taps; 6 is unused and reads low
  logic [SRC_COUNT-1:0] big_src;
  assign big_src = {taps, dhi, dlo, drail, rb_bit, 1'b0, dlk,
                    hold_r == HS_HOLD, lk1 && lk2, lk2, lk1, 1'b0};

  logic lock_sig, hold_sig, in0_sig, in1_sig;
  assign lock_sig = pick_src(lock_sel, big_src);
  assign hold_sig = pick_src(hold_sel, big_src);
  assign in0_sig = pick_small(in0_sel, {rb_bit, dhi, dlo, dlk,
                   choice_r == 2'h0, absent[0], 1'b0});
  assign in1_sig = pick_small(in1_sel, {rb_bit, dhi, dlo, dlk,
                   choice_r == 2'h1, absent[1], 1'b0});

  // an input-type code releases the pin, so the source code has no effect
  status_pin_driver u_lock_drv (
    .clock(clock), .rst_n(rst_n), .sig(lock_sig), .ptype(lock_type),
    .pin_drive(lock_pin), .pin_oe(lock_pin_oe));
  status_pin_driver u_hold_drv (
    .clock(clock), .rst_n(rst_n), .sig(hold_sig), .ptype(hold_type),
    .pin_drive(hold_pin), .pin_oe(hold_pin_oe));
  status_pin_driver u_in0_drv (
    .clock(clock), .rst_n(rst_n), .sig(in0_sig), .ptype(in0_type),
    .pin_drive(in0_pin_drive), .pin_oe(in0_pin_oe));
  status_pin_driver u_in1_drv (
    .clock(clock), .rst_n(rst_n), .sig(in1_sig), .ptype(in1_type),
    .pin_drive(in1_pin_drive), .pin_oe(in1_pin_oe));

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_loss
      ref_loss_monitor u_mon (
        .clock(clock), .rst_n(rst_n), .ref_pin(ref_in[gi]),
        .timeout_sel(los_sel), .absent(absent[gi]));
    end
  endgenerate

  // pins act as selects only while configured as inputs
  logic sel0, sel1;
  logic [1:0] pin_code;
  assign sel0 = (in0_type <= 3'(PT_IN_PD)) && (p0 ^ pol);
  assign sel1 = (in1_type <= 3'(PT_IN_PD)) && (p1 ^ pol);
  assign pin_code = {sel1, sel0};

  logic fall_evt;
  assign fall_evt = lock1_fall && !ignore;

  // holdover: entered on lock loss, left once the first loop relocks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_r <= HS_NORMAL;
    end else begin
      unique case (hold_r)
        HS_NORMAL: if (fall_evt && hmode == HOLD_EN) hold_r <= HS_HOLD;
        HS_HOLD: if (lk1 || hmode != HOLD_EN) hold_r <= HS_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_r <= 1'b0;
    end else begin
      event_r <= fall_evt;
    end
  end

  // pin code 3 names no input; pin mode keeps the present choice, mode 6 steps to the next enabled input
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      choice_r <= 2'h0;
    end else begin
      unique case (mode)
        RM_FORCE0, RM_FORCE1, RM_FORCE2: choice_r <= 2'(mode);
        RM_PINS: if (pin_code != 2'h3) choice_r <= pin_code;
        RM_AUTO: if (fall_evt) choice_r <= next_ref(choice_r, en);
        RM_AUTO_PIN: begin
          if (fall_evt) begin
            if (pin_code != 2'h3 && en[pin_code]) choice_r <= pin_code;
            else choice_r <= next_ref(choice_r, en);
          end
        end
        default: choice_r <= choice_r;
      endcase
    end
  end

  // gating relies on realign qualify staying clear elsewhere
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      realign_r <= 1'b0;
    end else begin
      realign_r <= (lock_hold_r[REALIGN2_BIT] && !lk2) ||
                   (lock_hold_r[REALIGN1_BIT] && !lk1);
    end
  end

  // freezing in holdover keeps the last good tuning for the DAC
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dac_r <= '0;
    end else if (track && hold_r == HS_NORMAL) begin
      dac_r <= tune_level;
    end
  end

  assign ref_choice = choice_r;
  assign holdover_active = (hold_r == HS_HOLD);
  assign switch_event = event_r;
  assign realign_hold = realign_r;
  assign dac_count_readback = dac_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_pp_low;
    (lock_type == 3'(PT_PP) && lock_sel == 5'h00) [*2];
  endsequence
  sequence s_inv_low;
    (lock_type == 3'(PT_INV) && lock_sel == 5'h00) [*2];
  endsequence

  property p_pp_low;
    s_pp_low |=> (!lock_pin && lock_pin_oe);
  endproperty
  a_pp_low: assert property (p_pp_low)
    else $error("push-pull low source not low");

  property p_inv_low;
    s_inv_low |=> (lock_pin && lock_pin_oe);
  endproperty
  a_inv_low: assert property (p_inv_low)
    else $error("inverted low source not high");

  property p_realign;
    (lock_hold_r[REALIGN2_BIT] && !lk2) |=> realign_hold;
  endproperty
  a_realign: assert property (p_realign)
    else $error("realignment released before second lock");

  property p_event;
    fall_evt |=> switch_event ##1 !switch_event;
  endproperty
  a_event: assert property (p_event)
    else $error("lock loss gave no single event pulse");

  property p_no_event;
    switch_event |-> !$past(ignore);
  endproperty
  a_no_event: assert property (p_no_event)
    else $error("switch event while loss detect ignored");

  property p_hold_enter;
    (fall_evt && hmode == HOLD_EN && hold_r == HS_NORMAL) |=>
      holdover_active;
  endproperty
  a_hold_enter: assert property (p_hold_enter)
    else $error("holdover not entered on lock loss");

  property p_hold_off;
    (hmode != HOLD_EN && hold_r == HS_NORMAL) |=> !holdover_active;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("holdover entered while disabled");

  property p_forced;
    (mode == RM_FORCE1) [*2] |-> ref_choice == 2'h1;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced input one not chosen");

  property p_auto_order;
    (mode == RM_AUTO && en == 3'h7 && fall_evt) |=>
      ref_choice == (($past(ref_choice) == 2'h2) ? 2'h0 :
                     $past(ref_choice) + 2'h1);
  endproperty
  a_auto_order: assert property (p_auto_order)
    else $error("auto switch broke input order");

  property p_track;
    (track && hold_r == HS_NORMAL) |=>
      dac_count_readback == $past(tune_level);
  endproperty
  a_track: assert property (p_track)
    else $error("DAC count not following tuning level");

  property p_latch_only;
    !latch_rise |=> ($stable(lock_hold_r) && $stable(pins_ref_r));
  endproperty
  a_latch_only: assert property (p_latch_only)
    else $error("register changed without latch");
endmodule

//--- test/cfg_host_model.sv
// host side of the three-wire config port, writes whole words
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic clock, // core clock
  output logic cfg_clk, // serial clock pin
  output logic cfg_data, // serial data pin
  output logic cfg_latch // latch pin
);
  initial begin
    cfg_clk = 1'h0;
    cfg_data = 1'h0;
    cfg_latch = 1'h0;
  end
  // each level held at least 3 core clocks so the synchroniser sees every edge
  task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] w;
    w = {d[31:5], a};
    for (int i = 31; i >= 0; i--) begin
      @(posedge clock) cfg_data <= w[i];
      repeat (3) @(posedge clock);
      cfg_clk <= 1'h1;
      repeat (3) @(posedge clock);
      cfg_clk <= 1'h0;
    end
    repeat (3) @(posedge clock);
    cfg_latch <= 1'h1; // whole word only
    repeat (3) @(posedge clock);
    cfg_latch <= 1'h0;
    cfg_data <= ~cfg_data; // no stale bit left on the line
  endtask
endmodule

//--- test/status_ctrl_test.sv
// self-checking bench for the status pin and reference select bank
`timescale 1ns/1ps
module status_ctrl_test;
  import status_ctrl_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic cfg_clk, cfg_data, cfg_latch;
  logic first_lock = 1'h0, second_lock = 1'h0, dac_locked = 1'h0;
  logic dac_rail = 1'h0, dac_low = 1'h0, dac_high = 1'h0;
  logic [7:0] div_taps = 8'h00;
  logic [9:0] tune_level = 10'h000;
  logic [2:0] ref_in = 3'h0;
  logic in0_ext = 1'h0, in1_ext = 1'h0;
  logic in0_lvl, in1_lvl, lock_pin, lock_pin_oe, hold_pin, hold_pin_oe;
  logic in0_pin_drive, in0_pin_oe, in1_pin_drive, in1_pin_oe;
  logic [1:0] ref_choice;
  logic holdover_active, switch_event, realign_hold;
  logic [9:0] dac_count_readback;
  int error_cnt = 0, checks_done = 0, cyc = 0, ev_cnt = 0;
  always #4 clock = ~clock;
  // wire level: our drive when enabled, otherwise the far side
  assign in0_lvl = in0_pin_oe ? in0_pin_drive : in0_ext;
  assign in1_lvl = in1_pin_oe ? in1_pin_drive : in1_ext;
  status_ctrl i_status_ctrl (
    .clock, .rst_n, .cfg_clk, .cfg_data, .cfg_latch, .first_lock,
    .second_lock, .dac_locked, .dac_rail, .dac_low, .dac_high, .div_taps,
    .tune_level, .ref_in, .in0_pin_level(in0_lvl), .in1_pin_level(in1_lvl),
    .lock_pin, .lock_pin_oe, .hold_pin, .hold_pin_oe, .in0_pin_drive,
    .in0_pin_oe, .in1_pin_drive, .in1_pin_oe, .ref_choice,
    .holdover_active, .switch_event, .realign_hold, .dac_count_readback
  );
  cfg_host_model i_cfg_host_model (.clock, .cfg_clk, .cfg_data, .cfg_latch);
  // counting per cycle also catches a pulse wider than one clock
  always @(posedge clock) if (switch_event === 1'h1) ev_cnt++;
  task automatic chk(input logic [9:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic w12(input logic [4:0] s, input logic [2:0] t,
                     input logic r2, r1, tr, input logic [1:0] hm);
    i_cfg_host_model.write_reg(ADDR_LOCK_HOLD,
      {s, t, r2, r1, 13'h0, tr, hm, 6'h0});
    repeat (8) @(posedge clock);
  endtask
  task automatic w13(input logic [4:0] s, input logic [2:0] t, s1, t0,
                     input logic ig, input logic [2:0] s0, md,
                     input logic pl, input logic [2:0] en);
    i_cfg_host_model.write_reg(ADDR_PINS_REF,
      {s, t, 1'h0, s1, 1'h0, t0, ig, s0, md, pl, en, 5'h0});
    repeat (8) @(posedge clock);
  endtask
  task automatic w0e(input logic [1:0] ls, input logic [2:0] t1);
    i_cfg_host_model.write_reg(ADDR_LOSS_CFG, {ls, 3'h0, t1, 24'h0});
    repeat (8) @(posedge clock);
  endtask
  function automatic logic big(input int c);
    case (c)
      1: return first_lock;
      2: return second_lock;
      3: return first_lock & second_lock;
      5: return dac_locked;
      8: return dac_rail;
      9: return dac_low;
      10: return dac_high;
      default: return (c >= 11 && c <= 18) ? div_taps[c-11] : 1'h0;
    endcase
  endfunction
  // loss reads high: reference pins do not toggle until after the source checks
  function automatic logic small_src(input int c, input logic ch);
    case (c)
      1: return 1'h1;
      2: return ch;
      3: return dac_locked;
      4: return dac_low;
      5: return dac_high;
      default: return 1'h0;
    endcase
  endfunction
  function automatic logic [1:0] pin(input int t, input logic s);
    case (t)
      3: return {1'h1, s};
      4: return {1'h1, ~s};
      5: return {s, 1'h1};
      6: return {~s, 1'h0};
      default: return 2'h0;
    endcase
  endfunction
  task automatic drop(input logic [9:0] n, input logic [1:0] ch,
                      input logic h);
    int e0;
    e0 = ev_cnt;
    @(posedge clock) first_lock <= 1'h0;
    repeat (8) @(posedge clock);
    chk(10'(ev_cnt - e0), n, "event count");
    chk(ref_choice, ch, "auto choice");
    chk(holdover_active, h, "holdover");
    @(posedge clock) first_lock <= 1'h1;
    repeat (8) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    first_lock <= 1'h1;
    dac_locked <= 1'h1;
    dac_low <= 1'h1;
    div_taps <= 8'ha5;
    repeat (4) @(posedge clock);
    chk({lock_pin_oe, lock_pin}, 2'h2, "lock reset");
    chk({in0_pin_oe, in1_pin_oe}, 2'h0, "in reset");
    note("reset");
    for (int t = 0; t < 8; t++)
      for (int s = 0; s < 2; s++) begin
        w12(s[4:0], t[2:0], 1'h0, 1'h0, 1'h0, 2'h1);
        w13(s[4:0], t[2:0], 3'h0, 3'h0, 1'h1, 3'h0, 3'h0, 1'h0, 3'h7);
        chk({lock_pin_oe, lock_pin}, pin(t, s[0]), "lock type");
        chk({hold_pin_oe, hold_pin}, pin(t, s[0]), "hold type");
      end
    note("types");
    for (int c = 0; c < SRC_COUNT; c++) begin
      if (c == 7) continue;
      w12(c[4:0], 3'h3, 1'h0, 1'h0, 1'h0, 2'h1);
      w13(c[4:0], 3'h3, 3'h0, 3'h0, 1'h1, 3'h0, 3'h0, 1'h0, 3'h7);
      chk(lock_pin, big(c), "lock source");
      chk(hold_pin, big(c), "hold source");
    end
    note("sources");
    w0e(2'h0, 3'h3);
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      w13(5'h0, 3'h3, c[2:0], 3'h3, 1'h1, c[2:0], 3'h0, 1'h0, 3'h7);
      chk(in0_pin_drive, small_src(c, 1'h1), "in0 source");
      chk(in1_pin_drive, small_src(c, 1'h0), "in1 source");
    end
    w0e(2'h0, 3'h0);
    chk(in1_pin_oe, 1'h0, "in1 input");
    for (int t = 0; t < 7; t++) begin
      w13(5'h0, 3'h3, 3'h3, t[2:0], 1'h1, 3'h3, 3'h0, 1'h0, 3'h7);
      chk({in0_pin_oe, in0_pin_drive}, pin(t, 1'h1), "in0 type");
    end
    w13(5'h0, 3'h3, 3'h0, 3'h3, 1'h1, 3'h1, 3'h0, 1'h0, 3'h7);
    for (int i = 0; i < 8; i++)
      @(posedge clock) ref_in[0] <= ~ref_in[0];
    repeat (100) @(posedge clock);
    chk(in0_pin_drive, 1'h0, "loss held off");
    repeat (60) @(posedge clock);
    chk(in0_pin_drive, 1'h1, "loss timeout");
    note("input pins");
    w12(5'h0, 3'h3, 1'h1, 1'h0, 1'h0, 2'h1); // qualify kept clear
    chk(realign_hold, 1'h1, "held second");
    @(posedge clock) second_lock <= 1'h1;
    repeat (6) @(posedge clock);
    chk(realign_hold, 1'h0, "free second");
    w12(5'h0, 3'h3, 1'h0, 1'h1, 1'h0, 2'h1);
    @(posedge clock) first_lock <= 1'h0;
    repeat (6) @(posedge clock);
    chk(realign_hold, 1'h1, "held first");
    note("realign");
    for (int m = 0; m < 3; m++) begin
      w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h1, 3'h0, m[2:0], 1'h0, 3'h7);
      chk(ref_choice, m[1:0], "forced");
    end
    @(posedge clock) in1_ext <= 1'h1;
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h1, 3'h0, 3'h3, 1'h0, 3'h7);
    chk(ref_choice, 2'h2, "pins high");
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h1, 3'h0, 3'h3, 1'h1, 3'h7);
    chk(ref_choice, 2'h1, "pins low");
    note("pin select");
    @(posedge clock) first_lock <= 1'h1;
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h0, 3'h0, 3'h0, 1'h0, 3'h7);
    w12(5'h0, 3'h3, 1'h0, 1'h0, 1'h0, 2'h2);
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h0, 3'h0, 3'h4, 1'h0, 3'h5);
    drop(10'h1, 2'h2, 1'h1);
    drop(10'h1, 2'h0, 1'h1);
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h1, 3'h0, 3'h4, 1'h0, 3'h5);
    drop(10'h0, 2'h0, 1'h0);
    w12(5'h0, 3'h3, 1'h0, 1'h0, 1'h0, 2'h1);
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h0, 3'h0, 3'h4, 1'h0, 3'h5);
    drop(10'h1, 2'h2, 1'h0);
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h0, 3'h0, 3'h4, 1'h0, 3'h7);
    drop(10'h1, 2'h0, 1'h0);
    w13(5'h0, 3'h3, 3'h0, 3'h0, 1'h0, 3'h0, 3'h6, 1'h0, 3'h7);
    drop(10'h1, 2'h2, 1'h0);
    note("auto switch");
    @(posedge clock) tune_level <= 10'h2b5;
    w12(5'h0, 3'h3, 1'h0, 1'h0, 1'h1, 2'h1);
    chk(dac_count_readback, 10'h2b5, "dac track");
    note("tracking");
    finish_test;
  end
endmodule
